// [shared/edt_pkg.sv]
// Shared constants and types for the encoder duty, interpolation and timestamp block
package edt_pkg;
    // Clock and internal time base
    localparam int CLK_PERIOD_NS = 50;
    localparam int TBASE_NS = 10;
    localparam int TICKS_PER_CLK = CLK_PERIOD_NS / TBASE_NS;
    localparam logic [31:0] TICKS_STEP = 32'(TICKS_PER_CLK);
    localparam logic [31:0] CNT_SAT = 32'hffff_ffff;
    // Duty cycle scaling and reset values
    localparam logic [15:0] DUTY_FULL = 16'h2710;
    localparam logic [15:0] DUTY_CUR_RST = 16'h0000;
    localparam logic [15:0] DUTY_MIN_RST = 16'h2710;
    localparam logic [15:0] DUTY_MAX_RST = 16'h0000;
    localparam int DUTY_QBITS = 14;
    // Request codes, channel index is added to the base
    localparam logic [15:0] REQ_CLR_MIN_BASE = 16'h9130;
    localparam logic [15:0] REQ_CLR_MAX_BASE = 16'h9140;
    // Interpolation
    localparam int MICRO_BITS = 8;
    localparam logic [7:0] MICRO_MAX = 8'hff;
    localparam int MICRO_STEPS = 256;
    localparam logic [32:0] MICRO_ACC_STEP = 33'(MICRO_STEPS * TICKS_PER_CLK);
    localparam int EXTRAP_LIMIT_NS = 1340;
    localparam logic [31:0] EXTRAP_LIMIT_TICKS = 32'(EXTRAP_LIMIT_NS / TBASE_NS);
    // Timestamps
    localparam int SYNC_STAGES = 2;
    localparam logic [63:0] SYNC_DELAY_NS = 64'(SYNC_STAGES * CLK_PERIOD_NS);
    localparam logic [63:0] TS_RST = 64'h0;
    localparam logic [63:0] TS_COMPACT_MASK = 64'h0000_0000_ffff_ffff;
    // Counter evaluation modes
    localparam logic [1:0] EVAL_4FOLD = 2'h0;
    localparam logic [1:0] EVAL_1FOLD = 2'h1;
    localparam logic [1:0] EVAL_2FOLD = 2'h2;
    // Pin vector positions
    localparam int PIN_A = 0;
    localparam int PIN_B = 1;
    localparam int PIN_C = 2;
    localparam int PIN_LATCH = 3;
    localparam int PIN_GATE = 4;
    localparam int PIN_NUM = 5;

    typedef struct packed {
        logic [1:0] eval_mode;
        logic micro_en;
        logic zero_latch_en;
        logic latch_pos_en;
        logic latch_neg_en;
        logic latch2_pos_en;
        logic latch2_neg_en;
        logic ts_compact;
        logic clock_synced_operation;
    } edt_cfg_t;

    typedef struct packed {
        logic valid;
        logic [15:0] code;
    } edt_req_t;

    typedef struct packed {
        logic [15:0] current;
        logic [15:0] minimum;
        logic [15:0] maximum;
    } edt_duty_t;

    typedef enum logic [1:0] {
        DS_WAIT = 2'b01,
        DS_MEAS = 2'b10
    } edt_duty_st_t;

    typedef enum logic [1:0] {
        DV_IDLE = 2'b01,
        DV_BUSY = 2'b10
    } edt_div_st_t;
endpackage

// [rtl/edt_in_sync.sv]
// Two-stage pin synchroniser with edge detection per bit
`timescale 1ns/1ps
module edt_in_sync
    import edt_pkg::*;
#(
    parameter int W = PIN_NUM
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] stab_ff;
    logic [W-1:0] prev_ff;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            // Edges only look at the second stage onward
            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    meta_ff[i] <= 1'b0;
                    stab_ff[i] <= 1'b0;
                    prev_ff[i] <= 1'b0;
                end else begin
                    meta_ff[i] <= pin[i];
                    stab_ff[i] <= meta_ff[i];
                    prev_ff[i] <= stab_ff[i];
                end
            end
            assign level[i] = stab_ff[i];
            assign rise[i] = stab_ff[i] & ~prev_ff[i];
            assign fall[i] = ~stab_ff[i] & prev_ff[i];
        end
    endgenerate
endmodule

// [rtl/edt_duty_div.sv]
// Sequential divider: duty = on_time * full scale / period, one quotient bit per clock
`timescale 1ns/1ps
module edt_duty_div
    import edt_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic start,
    input wire logic [31:0] on_time,
    input wire logic [31:0] period,
    output logic done,
    output logic [15:0] quotient
);
    edt_div_st_t st_ff;
    logic [47:0] rem_ff;
    logic [47:0] den_ff;
    logic [15:0] quo_ff;
    logic [3:0] bit_ff;
    logic done_ff;
    logic [47:0] trial;

    assign trial = den_ff << bit_ff;

    // Quotient never exceeds full scale since on-time is shorter than the period
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_ff <= DV_IDLE;
            rem_ff <= 48'h0;
            den_ff <= 48'h0;
            quo_ff <= 16'h0;
            bit_ff <= 4'h0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            case (st_ff)
                DV_IDLE: begin
                    if (start) begin
                        rem_ff <= {16'h0, on_time} * {32'h0, DUTY_FULL};
                        den_ff <= {16'h0, period};
                        quo_ff <= 16'h0;
                        bit_ff <= 4'(DUTY_QBITS - 1);
                        st_ff <= DV_BUSY;
                    end
                end
                DV_BUSY: begin
                    if (rem_ff >= trial) begin
                        rem_ff <= rem_ff - trial;
                        quo_ff[bit_ff] <= 1'b1;
                    end
                    if (bit_ff == 4'h0) begin
                        done_ff <= 1'b1;
                        st_ff <= DV_IDLE;
                    end else begin
                        bit_ff <= bit_ff - 4'h1;
                    end
                end
                default: st_ff <= DV_IDLE;
            endcase
        end
    end

    assign done = done_ff;
    assign quotient = quo_ff;
endmodule

// [rtl/edt_top.sv]
// Encoder duty cycle, micro-increment interpolation and timestamp capture
// Contract
// RULE_01: Duty cycle equals on-time over period, in 0.01 percent units, 10000 is full.
// RULE_02: On-time runs from a rising edge of track A to the next falling edge.
// RULE_03: Period runs between two successive rising edges of track A.
// RULE_04: Both intervals are counted on a 10 ns internal time base.
// RULE_05: Each controller cycle publishes the duty of its last complete period.
// RULE_06: Minimum duty starts at 10000 and follows the smallest value since clearing; after a clear it is held at zero.
// RULE_07: Maximum and current duty start at zero; maximum follows the largest value.
// RULE_08: Request 0x9130 zeroes channel 1 minimum, 0x9131 channel 2 minimum.
// RULE_09: Request 0x9140 zeroes channel 1 maximum, 0x9141 channel 2 maximum.
// RULE_10: Velocity from the period measurement drives 256 interpolated sub-steps per increment.
// RULE_11: Interpolation runs only when enabled and fills the counter's low 8 bits.
// RULE_12: Period at or below 1.34 us sets the extrapolation-overrun flag.
// RULE_13: While overrun is flagged the 8 interpolation bits read as zero.
// RULE_14: Controller should run clock-synchronous mode when using micro-increments.
// RULE_15: Controller must run clock-synchronous mode for timestamps to be available.
// RULE_16: Timestamps come from 64-bit system time; compact form keeps 32 bits.
// RULE_17: Count timestamp marks last counting edge, per evaluation mode 0, 1 or 2.
// RULE_18: Zero-pulse rising edge with latching enabled records the zero-pulse timestamp.
// RULE_19: Configured edge on latch or gate/latch input records that input's timestamp.
// RULE_20: A threshold-driven output switch records a timestamp for that output.
// RULE_21: Without a complete period in a cycle the published duty stays unchanged.
`timescale 1ns/1ps
module edt_top
    import edt_pkg::*;
#(
    parameter int CH_IDX = 0,
    parameter int N_OUT = 2
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic track_a,
    input wire logic track_b,
    input wire logic zero_pulse,
    input wire logic latch_in,
    input wire logic gate_latch_in,
    input wire logic [63:0] sys_time,
    input wire logic cycle_strobe,
    input wire edt_cfg_t cfg,
    input wire edt_req_t req,
    input wire logic [31:0] count_value,
    input wire logic count_up,
    input wire logic [N_OUT-1:0] out_switch,
    output edt_duty_t duty,
    output logic [31:0] reported_count,
    output logic extrap_stall,
    output logic [63:0] ts_count,
    output logic [63:0] ts_zero,
    output logic [63:0] ts_latch,
    output logic [63:0] ts_latch2,
    output logic [N_OUT-1:0][63:0] ts_out
);
    generate
        if (CH_IDX < 0 || CH_IDX > 1) begin : g_bad_ch
            $error("edt_top: CH_IDX must be 0 or 1");
        end
        if (N_OUT < 1) begin : g_bad_out
            $error("edt_top: N_OUT must be at least 1");
        end
    endgenerate

    logic [PIN_NUM-1:0] pins;
    logic [PIN_NUM-1:0] lvl;
    logic [PIN_NUM-1:0] rise;
    logic [PIN_NUM-1:0] fall;

    assign pins = {gate_latch_in, latch_in, zero_pulse, track_b, track_a};

    edt_in_sync #(
        .W(PIN_NUM)
    ) u_sync (
        .sys_clk(sys_clk),
        .srst(srst),
        .pin(pins),
        .level(lvl),
        .rise(rise),
        .fall(fall)
    );

    // Duty cycle measurement
    edt_duty_st_t dst_ff;
    logic [31:0] per_cnt_ff;
    logic [31:0] ton_ff;
    logic high_seen_ff;
    logic [31:0] per_now;
    logic period_done;
    logic div_done;
    logic [15:0] div_quo;
    logic [31:0] period_ff;

    // Interval including the current clock, held at full scale on overflow
    assign per_now = (per_cnt_ff > CNT_SAT - TICKS_STEP) ? CNT_SAT : per_cnt_ff + TICKS_STEP;
    assign period_done = rise[PIN_A] && (dst_ff == DS_MEAS);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            dst_ff <= DS_WAIT;
        end else begin
            case (dst_ff)
                DS_WAIT: begin
                    if (rise[PIN_A]) begin
                        dst_ff <= DS_MEAS;
                    end
                end
                DS_MEAS: dst_ff <= DS_MEAS;
                default: dst_ff <= DS_WAIT;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            per_cnt_ff <= 32'h0;
        end else if (rise[PIN_A]) begin
            per_cnt_ff <= 32'h0; // [RULE_03]
        end else begin
            per_cnt_ff <= per_now; // [RULE_04]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ton_ff <= 32'h0;
            high_seen_ff <= 1'b0;
        end else if (rise[PIN_A]) begin
            high_seen_ff <= 1'b1;
        end else if (fall[PIN_A] && high_seen_ff) begin
            ton_ff <= per_now; // [RULE_02]
            high_seen_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            period_ff <= 32'h0;
        end else if (period_done) begin
            period_ff <= per_now; // [RULE_03]
        end
    end

    edt_duty_div u_div (
        .sys_clk(sys_clk),
        .srst(srst),
        .start(period_done),
        .on_time(ton_ff),
        .period(per_now),
        .done(div_done),
        .quotient(div_quo)
    ); // [RULE_01]

    // Publishing and min/max tracking
    logic meas_ready_ff;
    logic [15:0] meas_val_ff;
    edt_duty_t duty_ff;
    logic clr_min;
    logic clr_max;
    logic [15:0] min_base;
    logic [15:0] max_base;

    assign clr_min = req.valid && (req.code == REQ_CLR_MIN_BASE + 16'(CH_IDX)); // [RULE_08]
    assign clr_max = req.valid && (req.code == REQ_CLR_MAX_BASE + 16'(CH_IDX)); // [RULE_09]
    assign min_base = clr_min ? 16'h0 : duty_ff.minimum;
    assign max_base = clr_max ? 16'h0 : duty_ff.maximum;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            meas_ready_ff <= 1'b0;
            meas_val_ff <= DUTY_CUR_RST;
        end else if (div_done && !cycle_strobe) begin
            meas_ready_ff <= 1'b1;
            meas_val_ff <= div_quo;
        end else if (cycle_strobe) begin
            meas_ready_ff <= 1'b0;
        end
    end

    // A result finishing on the strobe clock is published at once, not lost
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            duty_ff.current <= DUTY_CUR_RST; // [RULE_07]
        end else if (cycle_strobe && div_done) begin
            duty_ff.current <= div_quo; // [RULE_05]
        end else if (cycle_strobe && meas_ready_ff) begin
            duty_ff.current <= meas_val_ff; // [RULE_05]
        end
    end // [RULE_21]

    // A clear and a new value on one clock: the value is compared with the cleared base
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            duty_ff.minimum <= DUTY_MIN_RST; // [RULE_06]
        end else if (div_done && div_quo < min_base) begin
            duty_ff.minimum <= div_quo; // [RULE_06]
        end else begin
            duty_ff.minimum <= min_base; // [RULE_08]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            duty_ff.maximum <= DUTY_MAX_RST; // [RULE_07]
        end else if (div_done && div_quo > max_base) begin
            duty_ff.maximum <= div_quo; // [RULE_07]
        end else begin
            duty_ff.maximum <= max_base; // [RULE_09]
        end
    end

    assign duty = duty_ff;

    // Micro-increment interpolation
    logic count_edge;
    logic [31:0] incr_ticks_ff;
    logic stall_ff;
    logic [32:0] acc_ff;
    logic [32:0] acc_next;
    logic [7:0] micro_ff;
    logic [7:0] micro_eff;
    logic [31:0] rep_ff;

    always_comb begin
        case (cfg.eval_mode)
            EVAL_1FOLD: count_edge = rise[PIN_A];
            EVAL_2FOLD: count_edge = rise[PIN_A] | fall[PIN_A];
            default: count_edge = rise[PIN_A] | fall[PIN_A] | rise[PIN_B] | fall[PIN_B];
        endcase
    end // [RULE_17]

    // Time per increment is the A period split by the edges counted in it
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            incr_ticks_ff <= CNT_SAT;
        end else if (period_done) begin
            case (cfg.eval_mode)
                EVAL_1FOLD: incr_ticks_ff <= per_now;
                EVAL_2FOLD: incr_ticks_ff <= per_now >> 1;
                default: incr_ticks_ff <= per_now >> 2;
            endcase // [RULE_10]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            stall_ff <= 1'b0;
        end else if (period_done) begin
            stall_ff <= (per_now <= EXTRAP_LIMIT_TICKS); // [RULE_12]
        end
    end

    assign acc_next = acc_ff + MICRO_ACC_STEP;

    // At most one sub-step per clock: increments shorter than 256 clocks lag
    // and are caught up by the next real count edge.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            acc_ff <= 33'h0;
            micro_ff <= 8'h0;
        end else if (count_edge || !cfg.micro_en) begin
            acc_ff <= 33'h0;
            micro_ff <= 8'h0;
        end else if (micro_ff != MICRO_MAX) begin
            if (acc_next >= {1'b0, incr_ticks_ff}) begin
                acc_ff <= acc_next - {1'b0, incr_ticks_ff};
                micro_ff <= micro_ff + 8'h1; // [RULE_10]
            end else begin
                acc_ff <= acc_next;
            end
        end
    end

    assign micro_eff = stall_ff ? 8'h0 : micro_ff; // [RULE_13]

    // Position between counts is counter plus fraction going up, minus going down
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rep_ff <= 32'h0;
        end else if (!cfg.micro_en) begin
            rep_ff <= count_value;
        end else if (count_up) begin
            rep_ff <= {count_value[31-MICRO_BITS:0], micro_eff}; // [RULE_11]
        end else begin
            rep_ff <= {count_value[31-MICRO_BITS:0], 8'h0} - {24'h0, micro_eff}; // [RULE_11]
        end
    end

    assign reported_count = rep_ff;
    assign extrap_stall = stall_ff;

    // Timestamp capture
    logic [63:0] ts_pin_now;
    logic [63:0] ts_int_now;
    logic [63:0] ts_cnt_ff;
    logic [63:0] ts_zero_ff;
    logic [63:0] ts_latch_ff;
    logic [63:0] ts_latch2_ff;
    logic [N_OUT-1:0][63:0] ts_out_ff;
    logic zero_hit;
    logic latch_hit;
    logic latch2_hit;

    // Pin edges are seen after the synchroniser, so their stamps are moved back
    assign ts_pin_now = (sys_time - SYNC_DELAY_NS)
                        & (cfg.ts_compact ? TS_COMPACT_MASK : ~64'h0); // [RULE_16]
    assign ts_int_now = sys_time & (cfg.ts_compact ? TS_COMPACT_MASK : ~64'h0); // [RULE_16]

    assign zero_hit = cfg.zero_latch_en && rise[PIN_C];
    assign latch_hit = (cfg.latch_pos_en && rise[PIN_LATCH])
                       || (cfg.latch_neg_en && fall[PIN_LATCH]);
    assign latch2_hit = (cfg.latch2_pos_en && rise[PIN_GATE])
                        || (cfg.latch2_neg_en && fall[PIN_GATE]);

    // System time only means something with the controller clock-synchronised
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ts_cnt_ff <= TS_RST;
        end else if (count_edge && cfg.clock_synced_operation) begin
            ts_cnt_ff <= ts_pin_now; // [RULE_17] [RULE_15]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ts_zero_ff <= TS_RST;
        end else if (zero_hit && cfg.clock_synced_operation) begin
            ts_zero_ff <= ts_pin_now; // [RULE_18]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ts_latch_ff <= TS_RST;
            ts_latch2_ff <= TS_RST;
        end else if (cfg.clock_synced_operation) begin
            if (latch_hit) begin
                ts_latch_ff <= ts_pin_now; // [RULE_19]
            end
            if (latch2_hit) begin
                ts_latch2_ff <= ts_pin_now; // [RULE_19]
            end
        end
    end

    genvar k;
    generate
        for (k = 0; k < N_OUT; k++) begin : g_out_ts
            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    ts_out_ff[k] <= TS_RST;
                end else if (out_switch[k] && cfg.clock_synced_operation) begin
                    ts_out_ff[k] <= ts_int_now; // [RULE_20]
                end
            end
        end
    endgenerate

    assign ts_count = ts_cnt_ff;
    assign ts_zero = ts_zero_ff;
    assign ts_latch = ts_latch_ff;
    assign ts_latch2 = ts_latch2_ff;
    assign ts_out = ts_out_ff;
endmodule

// [tb/edt_enc_model.sv]
// Behavioural incremental encoder: quadrature tracks and zero pulse
`timescale 1ns/1ps
module edt_enc_model (
    input wire logic sys_clk,
    output logic track_a,
    output logic track_b,
    output logic zero_pulse
);
    // Edges move on falling clock edges only, so sampling never races them
    initial begin
        track_a = 1'b0;
        track_b = 1'b0;
        zero_pulse = 1'b0;
    end
    // One track A period: B rises mid-high and falls mid-low, lagging A
    task automatic period(input int hi, input int per);
        track_a = 1'b1;
        repeat (hi / 2) @(negedge sys_clk);
        track_b = 1'b1;
        repeat (hi - hi / 2) @(negedge sys_clk);
        track_a = 1'b0;
        repeat ((per - hi) / 2) @(negedge sys_clk);
        track_b = 1'b0;
        repeat (per - hi - (per - hi) / 2) @(negedge sys_clk);
    endtask
    task automatic toggle(input int idx);
        case (idx)
            0: track_a = ~track_a;
            1: track_b = ~track_b;
            default: zero_pulse = ~zero_pulse;
        endcase
    endtask
endmodule

// [tb/edt_top_props.sv]
// Concurrent checks on the ports of the duty, interpolation and timestamp block
`timescale 1ns/1ps
module edt_top_props
    import edt_pkg::*;
#(
    parameter int CH_IDX = 0,
    parameter int N_OUT = 2
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [63:0] sys_time,
    input wire logic cycle_strobe,
    input wire edt_cfg_t cfg,
    input wire edt_req_t req,
    input wire logic [31:0] count_value,
    input wire logic [N_OUT-1:0] out_switch,
    input wire edt_duty_t duty,
    input wire logic [31:0] reported_count,
    input wire logic extrap_stall,
    input wire logic [63:0] ts_count,
    input wire logic [63:0] ts_zero,
    input wire logic [63:0] ts_latch,
    input wire logic [N_OUT-1:0][63:0] ts_out
);
    logic [15:0] clr_min;
    logic [15:0] clr_max;
    assign clr_min = REQ_CLR_MIN_BASE + 16'(CH_IDX);
    assign clr_max = REQ_CLR_MAX_BASE + 16'(CH_IDX);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    sequence s_clear_min;
        req.valid && req.code == clr_min;
    endsequence
    // Three stalled cycles flush the registered micro value first
    sequence s_stalled;
        (extrap_stall && cfg.micro_en) [*3];
    endsequence
    sequence s_unsynced;
        !cfg.clock_synced_operation [*3];
    endsequence

    a_reset_vals: assert property ($fell(srst) |->
        duty == {DUTY_CUR_RST, DUTY_MIN_RST, DUTY_MAX_RST} && !extrap_stall)
        else $error("values after reset wrong");
    a_min_clear: assert property (s_clear_min |=> duty.minimum == 16'h0000)
        else $error("minimum not cleared");
    a_min_falls: assert property (!(req.valid && req.code == clr_min) |=>
        duty.minimum <= $past(duty.minimum)) else $error("minimum rose");
    a_max_rises: assert property (!(req.valid && req.code == clr_max) |=>
        duty.maximum >= $past(duty.maximum)) else $error("maximum fell");
    a_cur_hold: assert property (!cycle_strobe |=> $stable(duty.current))
        else $error("current duty moved off strobe");
    a_duty_range: assert property (duty.current <= DUTY_FULL && duty.maximum <= DUTY_FULL)
        else $error("duty above full scale");
    a_micro_off: assert property (!cfg.micro_en ##1 !cfg.micro_en |->
        reported_count == $past(count_value)) else $error("count altered while disabled");
    a_stall_bits: assert property (s_stalled |-> reported_count[7:0] == 8'h00)
        else $error("micro bits not zero in stall");
    a_ts_gated: assert property (s_unsynced |->
        $stable(ts_count) && $stable(ts_zero) && $stable(ts_latch))
        else $error("stamp taken while unsynced");
    a_out_stamp: assert property (
        cfg.clock_synced_operation && !cfg.ts_compact && out_switch[N_OUT-1] |=>
        ts_out[N_OUT-1] == $past(sys_time)) else $error("output stamp wrong");
endmodule

// [tb/test_edt_top.sv]
// Self-checking bench for the duty, interpolation and timestamp block
`timescale 1ns/1ps
module test_edt_top
    import edt_pkg::*;
;
    localparam int NO = 2;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic track_a, track_b, zero_pulse, extrap_stall;
    logic latch_in = 1'b0;
    logic gate_latch_in = 1'b0;
    logic cycle_strobe = 1'b0;
    logic count_up = 1'b1;
    logic [31:0] count_value = 32'h0012_3456;
    logic [31:0] reported_count;
    logic [63:0] sys_time = 64'h0000_0001_0000_0000;
    logic [63:0] ts_count, ts_zero, ts_latch, ts_latch2, exp_ts, t;
    logic [NO-1:0] out_switch = '0;
    logic [NO-1:0][63:0] ts_out;
    edt_cfg_t cfg = '0;
    edt_req_t req = '0;
    edt_duty_t duty;
    int mismatches = 0;
    int checks_done = 0;
    int hi_tab[5] = '{10, 4, 17, 3, 9};

    edt_enc_model i_enc (.sys_clk(sys_clk), .track_a(track_a), .track_b(track_b),
        .zero_pulse(zero_pulse));
    edt_top #(.CH_IDX(0), .N_OUT(NO)) i_dut (.*);

    always #25 sys_clk = ~sys_clk;
    always @(negedge sys_clk) sys_time <= sys_time + 64'h32;

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic clk(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic strobe();
        cycle_strobe = 1'b1;
        clk(1);
        cycle_strobe = 1'b0;
        clk(1);
    endtask
    task automatic send(input logic [15:0] code);
        req = {1'b1, code};
        clk(1);
        req.valid = 1'b0;
        clk(1);
    endtask
    function automatic logic [15:0] dc(input int hi, input int per);
        return 16'(hi * TICKS_PER_CLK * 10000 / (per * TICKS_PER_CLK));
    endfunction
    // Pins 0..2 belong to the encoder, 3 and 4 are the latch inputs
    task automatic stamp(input int idx, input bit hit, input int sel);
        logic [63:0] seen;
        if (idx < 3) i_enc.toggle(idx);
        else if (idx == 3) latch_in = ~latch_in;
        else gate_latch_in = ~gate_latch_in;
        #1;
        if (hit) exp_ts = cfg.ts_compact ? sys_time & TS_COMPACT_MASK : sys_time;
        clk(4);
        seen = sel == 0 ? ts_count : sel == 1 ? ts_zero : sel == 2 ? ts_latch : ts_latch2;
        check(seen, exp_ts);
    endtask

    initial begin
        #200000;
        mismatches++;
        stop_test();
    end

    initial begin
        clk(6);
        srst = 1'b0;
        clk(1);
        check(duty, {16'h0000, 16'h2710, 16'h0000});
        foreach (hi_tab[i]) begin
            i_enc.period(hi_tab[i], 20);
            if (i == 1) begin
                strobe();
                check(duty.current, dc(hi_tab[0], 20));
            end
        end
        strobe();
        check(duty, {dc(3, 20), dc(3, 20), dc(17, 20)});
        clk(3);
        strobe();
        check(duty.current, dc(3, 20));
        send(16'h9131);
        send(16'h9141);
        check(duty, {dc(3, 20), dc(3, 20), dc(17, 20)});
        send(16'h9130);
        check(duty.minimum, 16'h0000);
        send(16'h9140);
        check(duty.maximum, 16'h0000);
        // Strobes and requests stretch the last period to 35 clocks
        i_enc.period(5, 20);
        check(duty, {dc(3, 20), 16'h0000, dc(9, 35)});
        cfg.clock_synced_operation = 1'b1;
        cfg.micro_en = 1'b1;
        i_enc.period(13, 26);
        i_enc.period(13, 27);
        check(extrap_stall, 1'b1);
        check(reported_count[7:0], 8'h00);
        fork
            i_enc.period(13, 27);
            begin
                clk(25);
                check(extrap_stall, 1'b0);
                check(reported_count[31:8], count_value[23:0]);
                check(reported_count[7:0] != 8'h00, 1'b1);
                count_up = 1'b0;
                clk(1);
                check(reported_count[31:8], count_value[23:0] - 24'h1);
                count_up = 1'b1;
            end
        join
        cfg.micro_en = 1'b0;
        cfg.clock_synced_operation = 1'b1;
        for (int m = 0; m < 3; m++) begin
            cfg.eval_mode = 2'(m);
            stamp(1, m == 0, 0);
            stamp(0, 1'b1, 0);
            stamp(0, m != 1, 0);
        end
        cfg.zero_latch_en = 1'b1;
        stamp(2, 1'b1, 1);
        stamp(2, 1'b0, 1);
        cfg.latch_pos_en = 1'b1;
        stamp(3, 1'b1, 2);
        stamp(3, 1'b0, 2);
        cfg.latch2_neg_en = 1'b1;
        exp_ts = TS_RST;
        stamp(4, 1'b0, 3);
        stamp(4, 1'b1, 3);
        cfg.ts_compact = 1'b1;
        stamp(3, 1'b1, 2);
        cfg.ts_compact = 1'b0;
        cfg.clock_synced_operation = 1'b0;
        stamp(3, 1'b0, 2);
        stamp(3, 1'b0, 2);
        cfg.clock_synced_operation = 1'b1;
        out_switch[NO-1] = 1'b1;
        #1 t = sys_time;
        clk(1);
        out_switch = '0;
        clk(2);
        check(ts_out[NO-1], t);
        check(ts_out[0], TS_RST);
        srst = 1'b1;
        clk(2);
        srst = 1'b0;
        clk(1);
        check(duty, {16'h0000, 16'h2710, 16'h0000});
        check(ts_latch, TS_RST);
        stop_test();
    end
endmodule

bind edt_top edt_top_props #(.CH_IDX(CH_IDX), .N_OUT(N_OUT)) i_props (.*);
